// ===== rtl/spm_clkgen.sv
// master smbus clock generator, runs only while busy
`timescale 1ns/10ps
module spm_clkgen
    import spm_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // control
    input  wire logic         slow_q_in,
    input  wire logic         start,
    input  wire logic [7:0]   n_bits,
    // status and pin
    output logic              busy,
    output logic              scl_oe
);
    import spm_pkg::*;
    spm_mst_t          st_q;
    logic [DIV_W-1:0]  cnt_q;
    logic [7:0]        bits_q;
    logic [DIV_W-1:0]  half;
    // speed comes only from the latched strap
    assign half = slow_q_in ? DIV_W'(SLOW_HALF - 1) : DIV_W'(FAST_HALF - 1);
    assign busy = (st_q != SPM_IDLE);
    // open drain: enable pulls low
    assign scl_oe = (st_q == SPM_LOW);
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q   <= SPM_IDLE;
            cnt_q  <= '0;
            bits_q <= '0;
        end else begin
            case (st_q)
                SPM_IDLE: begin
                    if (start && n_bits != 8'h00) begin
                        st_q   <= SPM_LOW;
                        cnt_q  <= half;
                        bits_q <= n_bits;
                    end
                end
                SPM_LOW: begin
                    if (cnt_q == '0) begin
                        st_q  <= SPM_HIGH;
                        cnt_q <= half;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                SPM_HIGH: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (bits_q == 8'h01) begin
                        st_q <= SPM_IDLE;
                    end else begin
                        st_q   <= SPM_LOW;
                        cnt_q  <= half;
                        bits_q <= bits_q - 8'h01;
                    end
                end
                default: st_q <= SPM_IDLE;
            endcase
        end
    end
endmodule

// ===== rtl/spm_pkg.sv
// package for the switch pin configuration and gpio mux
// Functional notes
// - eeprom bus address from four master straps
// - master clock toggles only during accesses
// - slave answers only strap-formed address
// - each gpio pin selectable gpio or alternate
// - gpio 0,1,8,9,10 drive port reset outputs
// - gpio 2..5 take expander interrupt inputs
// - gpio 6 alternate is plain undefined input
// - gpio 7 alternate drives event output low
// - downstream shared refclk strap honoured
// - upstream shared refclk strap honoured
// - master bus 100 kHz slow, else 400
// - bus speed fixed by strap only
// - merge low joins ports into x8
// - merge high keeps two x4 ports
// - names ending low are active low
package spm_pkg;
    localparam int GPIO_W = 11;
    localparam int CLK_HZ = 25_000_000;
    localparam int SLOW_HZ = 100_000;
    localparam int FAST_HZ = 400_000;
    // half bit periods, rounded down, so the fast bus runs slightly over rate
    localparam int SLOW_HALF = CLK_HZ / (2 * SLOW_HZ);
    localparam int FAST_HALF = CLK_HZ / (2 * FAST_HZ);
    localparam int DIV_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_GPIO_ALT  = 8'h00;
    localparam logic [7:0] OFS_GPIO_OUT  = 8'h04;
    localparam logic [7:0] OFS_GPIO_OE   = 8'h08;
    localparam logic [7:0] OFS_GPIO_IN   = 8'h0C;
    localparam logic [7:0] OFS_PORT_RST  = 8'h10;
    localparam logic [7:0] OFS_EVENT     = 8'h14;
    localparam logic [7:0] OFS_STRAPS    = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
    localparam logic [7:0] OFS_BUS_REQ   = 8'h24;
    localparam logic [7:0] OFS_BUS_STAT  = 8'h28;
    localparam logic [7:0] OFS_SLV_ADDR  = 8'h2C;
    // reset values
    localparam logic [10:0] RST_GPIO_ALT = 11'h000;
    localparam logic [4:0]  RST_PORT_RST = 5'h1F;
    localparam logic [3:0]  RST_IRQ_MASK = 4'h0;
    // strap bundle
    typedef struct packed {
        logic [3:0] eeprom_addr;
        logic [3:0] slave_addr;
        logic       ds_shared;
        logic       us_shared;
        logic       slow;
        logic       merge01;
    } spm_straps_t;
    // master clock engine states
    typedef enum logic [1:0] {SPM_IDLE, SPM_LOW, SPM_HIGH} spm_mst_t;
endpackage

// ===== rtl/spm_top.sv
// pin configuration, strap capture and gpio alternate mux
`timescale 1ns/10ps
module spm_top
    import spm_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    output logic                       irq,
    // straps
    input  wire logic [3:0]            eeprom_addr_strap,
    input  wire logic [3:0]            slave_addr_strap,
    input  wire logic                  downstream_shared_refclk,
    input  wire logic                  upstream_shared_refclk,
    input  wire logic                  master_bus_slow_sel,
    input  wire logic                  first_pair_merge_low,
    // master smbus clock pin
    input  wire logic                  master_bus_clock_i,
    output logic                       master_bus_clock_o,
    output logic                       master_bus_clock_oe,
    // gpio pins
    input  wire logic [spm_pkg::GPIO_W-1:0] gpio_i,
    output logic [spm_pkg::GPIO_W-1:0]      gpio_o,
    output logic [spm_pkg::GPIO_W-1:0]      gpio_oe,
    // decoded configuration to the core
    output logic [6:0]                 eeprom_bus_addr,
    output logic [6:0]                 slave_bus_addr,
    output logic                       slave_addr_hit,
    input  wire logic [6:0]            slave_rx_addr,
    output logic                       ds_common_clk,
    output logic                       us_common_clk,
    output logic                       master_bus_slow,
    output logic                       port0_x8,
    output logic [3:0]                 port0_lane_count,
    output logic [3:0]                 port1_lane_count,
    output logic [3:0]                 expander_irq
);
    import spm_pkg::*;

    spm_straps_t       straps_q;
    logic [10:0]       alt_q;
    logic [10:0]       out_q;
    logic [10:0]       oe_q;
    logic [4:0]        prst_q;
    logic              event_q;
    logic [3:0]        stat_q;
    logic [3:0]        mask_q;
    logic [3:0]        exp_d;
    logic [3:0]        exp_prev_q;
    logic [3:0]        exp_rise;
    logic [31:0]       prdata_d;
    logic              rd_ok;
    logic              acc;
    logic              wr;
    logic              rd;
    logic              mst_busy;
    logic              mst_start;
    logic [7:0]        mst_bits_q;
    logic              mst_start_q;
    logic [10:0]       alt_o;

    // straps are latched while reset is held and then frozen
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            straps_q.eeprom_addr <= eeprom_addr_strap;
            straps_q.slave_addr  <= slave_addr_strap;
            straps_q.ds_shared   <= downstream_shared_refclk;
            straps_q.us_shared   <= upstream_shared_refclk;
            straps_q.slow        <= master_bus_slow_sel;
            straps_q.merge01     <= first_pair_merge_low;
        end
    end

    // eeprom address: fixed 101 above the four strap bits
    assign eeprom_bus_addr = {2'b10, 1'b1, straps_q.eeprom_addr};
    // slave address: strap bits at 5,3,2,1, fixed ones elsewhere
    assign slave_bus_addr = {1'b1, straps_q.slave_addr[3], 1'b1, straps_q.slave_addr[2:0], 1'b1};
    assign slave_addr_hit = (slave_rx_addr == slave_bus_addr);
    assign ds_common_clk = straps_q.ds_shared;
    assign us_common_clk = straps_q.us_shared;
    assign master_bus_slow = straps_q.slow;
    // active-low merge pin: low means merged
    assign port0_x8 = !straps_q.merge01;
    assign port0_lane_count = port0_x8 ? 4'h8 : 4'h4;
    assign port1_lane_count = port0_x8 ? 4'h0 : 4'h4;

    // apb: zero wait states, unmapped reads zero with error
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        prdata_d = 32'h0000_0000;
        rd_ok = 1'b1;
        case (paddr)
            OFS_GPIO_ALT: prdata_d = {21'h0, alt_q};
            OFS_GPIO_OUT: prdata_d = {21'h0, out_q};
            OFS_GPIO_OE:  prdata_d = {21'h0, oe_q};
            OFS_GPIO_IN:  prdata_d = {21'h0, gpio_i};
            OFS_PORT_RST: prdata_d = {27'h0, prst_q};
            OFS_EVENT:    prdata_d = {31'h0, event_q};
            OFS_STRAPS:   prdata_d = {20'h0, straps_q};
            OFS_IRQ_STAT: prdata_d = {28'h0, stat_q};
            OFS_IRQ_MASK: prdata_d = {28'h0, mask_q};
            OFS_BUS_REQ:  prdata_d = {24'h0, mst_bits_q};
            OFS_BUS_STAT: prdata_d = {31'h0, mst_busy};
            OFS_SLV_ADDR: prdata_d = {25'h0, slave_bus_addr};
            default:      rd_ok = 1'b0;
        endcase
    end
    assign prdata = prdata_d;
    assign pslverr = acc && !rd_ok;

    // gpio configuration registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            alt_q <= RST_GPIO_ALT;
            out_q <= '0;
            oe_q  <= '0;
        end else if (wr) begin
            if (paddr == OFS_GPIO_ALT) alt_q <= pwdata[10:0];
            if (paddr == OFS_GPIO_OUT) out_q <= pwdata[10:0];
            if (paddr == OFS_GPIO_OE)  oe_q  <= pwdata[10:0];
        end
    end

    // port resets and event, software held; 1 means asserted
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            prst_q  <= RST_PORT_RST;
            event_q <= 1'b0;
        end else if (wr) begin
            if (paddr == OFS_PORT_RST) prst_q  <= pwdata[4:0];
            if (paddr == OFS_EVENT)    event_q <= pwdata[0];
        end
    end

    // alternate function output values, active low on the pin
    always_comb begin
        alt_o = '1;
        alt_o[0]  = !prst_q[1];
        alt_o[1]  = !prst_q[3];
        alt_o[8]  = !prst_q[0];
        alt_o[9]  = !prst_q[2];
        alt_o[10] = !prst_q[4];
        alt_o[7]  = !event_q;
    end

    // per pin mux: alternate inputs (2..6) never drive the pin
    genvar g;
    generate
        for (g = 0; g < GPIO_W; g++) begin : g_pin
            if (g >= 2 && g <= 6) begin : g_in
                assign gpio_o[g]  = out_q[g];
                assign gpio_oe[g] = alt_q[g] ? 1'b0 : oe_q[g];
            end else begin : g_out
                assign gpio_o[g]  = alt_q[g] ? alt_o[g] : out_q[g];
                assign gpio_oe[g] = alt_q[g] ? 1'b1 : oe_q[g];
            end
        end
    endgenerate

    // expander interrupts: low pin asserted, only in alternate mode
    assign exp_d = ~gpio_i[5:2] & alt_q[5:2];
    assign expander_irq = exp_d;
    assign exp_rise = exp_d & ~exp_prev_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            exp_prev_q <= '0;
        end else begin
            exp_prev_q <= exp_d;
        end
    end

    // sticky status, read clears; a new event in that cycle wins
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stat_q <= '0;
        end else if (rd && paddr == OFS_IRQ_STAT) begin
            stat_q <= exp_rise;
        end else begin
            stat_q <= stat_q | exp_rise;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mask_q <= RST_IRQ_MASK;
        end else if (wr && paddr == OFS_IRQ_MASK) begin
            mask_q <= pwdata[3:0];
        end
    end
    assign irq = |(stat_q & mask_q);

    // master bus clock kick; write of bit count starts a burst
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mst_bits_q  <= '0;
            mst_start_q <= 1'b0;
        end else begin
            mst_start_q <= wr && paddr == OFS_BUS_REQ && !mst_busy;
            if (wr && paddr == OFS_BUS_REQ && !mst_busy) mst_bits_q <= pwdata[7:0];
        end
    end
    assign mst_start = mst_start_q;

    spm_clkgen u_clkgen (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .slow_q_in (straps_q.slow),
        .start     (mst_start),
        .n_bits    (mst_bits_q),
        .busy      (mst_busy),
        .scl_oe    (master_bus_clock_oe)
    );
    // open drain: drive zero only, pin released when idle
    assign master_bus_clock_o = 1'b0;
endmodule

// ===== test/spm_board.sv
// board model: straps, pull-ups and expander interrupt lines
`timescale 1ns/10ps
module spm_board
    import spm_pkg::*;
(
    // scenario control
    input  wire logic        cfg,
    input  wire logic        wiggle,
    input  wire logic [3:0]  exp_req,
    // device pins
    input  wire logic [10:0] gpio_o,
    input  wire logic [10:0] gpio_oe,
    input  wire logic        mclk_oe,
    output spm_straps_t      straps,
    output logic [10:0]      gpio_i,
    output logic             mclk_i
);
    // flipping after reset proves the device kept its capture
    assign straps = spm_straps_t'((cfg ? 12'hCA6 : 12'h539) ^ {12{wiggle}});
    assign mclk_i = !mclk_oe;
    always_comb begin
        for (int k = 0; k < 11; k++) begin
            gpio_i[k] = gpio_oe[k] ? gpio_o[k] : 1'b1;
        end
        gpio_i[5:2] = gpio_i[5:2] & ~exp_req;
    end
endmodule

// ===== test/spm_top_monitor.sv
// port assertions for the pin configuration block
`timescale 1ns/10ps
module spm_top_monitor
    import spm_pkg::*;
(
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    // straps and pins
    input wire logic [3:0]             eeprom_addr_strap,
    input wire logic                   downstream_shared_refclk,
    input wire logic                   upstream_shared_refclk,
    input wire logic                   master_bus_slow_sel,
    input wire logic                   first_pair_merge_low,
    input wire logic [spm_pkg::GPIO_W-1:0] gpio_i,
    input wire logic                   master_bus_clock_o,
    input wire logic                   master_bus_clock_oe,
    // decoded outputs
    input wire logic [6:0]             eeprom_bus_addr,
    input wire logic [6:0]             slave_bus_addr,
    input wire logic                   slave_addr_hit,
    input wire logic [6:0]             slave_rx_addr,
    input wire logic                   ds_common_clk,
    input wire logic                   us_common_clk,
    input wire logic                   master_bus_slow,
    input wire logic                   port0_x8,
    input wire logic [3:0]             port0_lane_count,
    input wire logic [3:0]             port1_lane_count,
    input wire logic [3:0]             expander_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // length of the current pulled-low stretch
    logic [7:0] low_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn || !master_bus_clock_oe) low_q <= 8'h00;
        else low_q <= low_q + 8'h01;
    end
    sequence s_release;
        $fell(master_bus_clock_oe);
    endsequence
    sequence s_boot;
        $rose(rstn);
    endsequence
    property p_eep; s_boot |-> eeprom_bus_addr[3:0] == $past(eeprom_addr_strap); endproperty
    a_eep: assert property (p_eep) else $error("eeprom address differs from straps");
    property p_hit; slave_addr_hit == (slave_rx_addr == slave_bus_addr); endproperty
    a_hit: assert property (p_hit) else $error("slave match wrong");
    property p_half; s_release |-> low_q == (master_bus_slow ? SLOW_HALF : FAST_HALF); endproperty
    a_half: assert property (p_half) else $error("clock half period wrong");
    // pulled low only for one half period at the strapped rate
    property p_drv;
        master_bus_clock_oe |-> !master_bus_clock_o && low_q < (master_bus_slow ? SLOW_HALF : FAST_HALF);
    endproperty
    a_drv: assert property (p_drv) else $error("clock pin driven high or held low too long");
    property p_exp; (expander_irq & gpio_i[5:2]) == 4'h0; endproperty
    a_exp: assert property (p_exp) else $error("expander irq with pin high");
    property p_x8; port0_x8 |-> port0_lane_count == 4'h8 && port1_lane_count == 4'h0; endproperty
    a_x8: assert property (p_x8) else $error("merged lane counts wrong");
    property p_x4; !port0_x8 |-> port0_lane_count == 4'h4 && port1_lane_count == 4'h4; endproperty
    a_x4: assert property (p_x4) else $error("split lane counts wrong");
    property p_cap;
        s_boot |-> {ds_common_clk, us_common_clk, master_bus_slow, port0_x8} == {$past(downstream_shared_refclk),
            $past(upstream_shared_refclk), $past(master_bus_slow_sel), !$past(first_pair_merge_low)};
    endproperty
    a_cap: assert property (p_cap) else $error("strap capture wrong");
    property p_hold;
        $past(rstn) |-> $stable({eeprom_bus_addr, slave_bus_addr, ds_common_clk, us_common_clk, master_bus_slow});
    endproperty
    a_hold: assert property (p_hold) else $error("strap value moved after reset");
endmodule
bind spm_top spm_top_monitor u_mon (.clk_sys, .rstn, .eeprom_addr_strap, .downstream_shared_refclk,
    .upstream_shared_refclk, .master_bus_slow_sel, .first_pair_merge_low, .gpio_i, .master_bus_clock_o,
    .master_bus_clock_oe, .eeprom_bus_addr, .slave_bus_addr, .slave_addr_hit, .slave_rx_addr, .ds_common_clk,
    .us_common_clk, .master_bus_slow, .port0_x8, .port0_lane_count, .port1_lane_count, .expander_irq);

// ===== test/switch_pin_config_and_gpio_mux_bench.sv
// self-checking bench for the pin configuration block
`timescale 1ns/10ps
module switch_pin_config_and_gpio_mux_bench;
    import spm_pkg::*;
    localparam int PIN_OF [5] = '{8, 0, 9, 1, 10};
    logic        clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_q;
    logic        pready, pslverr, irq, err_q, mclk_i, mclk_o, master_bus_clock_oe, cfg = 1'b0, wiggle = 1'b0;
    logic [3:0]  exp_req = 4'h0, port0_lane_count, port1_lane_count, expander_irq;
    logic [10:0] gpio_i, gpio_o, gpio_oe;
    logic [6:0]  eeprom_bus_addr, slave_bus_addr, slave_rx_addr = 7'h00;
    logic        slave_addr_hit, ds_common_clk, us_common_clk, master_bus_slow, port0_x8;
    spm_straps_t st;
    int          fail_count = 0, n_tests = 0, hi_n = 0;
    spm_top DUT (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .irq,
        .eeprom_addr_strap(st.eeprom_addr), .slave_addr_strap(st.slave_addr), .downstream_shared_refclk(st.ds_shared),
        .upstream_shared_refclk(st.us_shared), .master_bus_slow_sel(st.slow), .first_pair_merge_low(st.merge01),
        .master_bus_clock_i(mclk_i), .master_bus_clock_o(mclk_o), .master_bus_clock_oe, .gpio_i, .gpio_o,
        .gpio_oe, .eeprom_bus_addr, .slave_bus_addr, .slave_addr_hit, .slave_rx_addr, .ds_common_clk,
        .us_common_clk, .master_bus_slow, .port0_x8, .port0_lane_count, .port1_lane_count, .expander_irq);
    spm_board u_board (.cfg, .wiggle, .exp_req, .gpio_o, .gpio_oe, .mclk_oe(master_bus_clock_oe), .straps(st),
        .gpio_i, .mclk_i);
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (master_bus_clock_oe === 1'b1) hi_n <= hi_n + 1;
    task automatic end_sim;
        if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic boot(input logic c);
        rstn <= 1'b0;
        wiggle <= 1'b0;
        cfg <= c;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        wiggle <= 1'b1;
        @(posedge clk_sys);
    endtask
    // two bits, so the pulled-low time is twice one half period
    task automatic burst(input int half);
        int h0;
        h0 = hi_n;
        apb(1'b1, OFS_BUS_REQ, 32'h0000_0002);
        apb(1'b0, OFS_BUS_STAT, 32'h0000_0000);
        chk("busy", rd_q[0], 1'b1);
        while (rd_q[0] !== 1'b0) begin
            apb(1'b0, OFS_BUS_STAT, 32'h0000_0000);
        end
        chk("clock low cycles", hi_n - h0, 2 * half);
        repeat (20) @(posedge clk_sys);
        chk("clock idle", master_bus_clock_oe, 1'b0);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_sim;
    end
    initial begin
        boot(1'b0);
        chk("eeprom addr", eeprom_bus_addr[3:0], 4'h5);
        chk("slave addr", slave_bus_addr & 7'h2E, 7'h06);
        chk("split lanes", {port0_x8, port0_lane_count, port1_lane_count}, 9'h044);
        chk("shared clk", {ds_common_clk, us_common_clk}, 2'b10);
        apb(1'b0, OFS_PORT_RST, 32'h0000_0000);
        chk("port reset value", rd_q, 32'h0000_001F);
        chk("oe at reset", gpio_oe, 11'h000);
        apb(1'b0, 8'h3C, 32'h0000_0000);
        chk("unmapped", {err_q, rd_q}, 33'h1_0000_0000);
        apb(1'b1, OFS_STRAPS, 32'hFFFF_FFFF);
        apb(1'b0, OFS_STRAPS, 32'h0000_0000);
        chk("straps", rd_q, 32'h0000_0539);
        burst(FAST_HALF);
        apb(1'b1, OFS_GPIO_ALT, 32'h0000_07FF);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, OFS_PORT_RST, 32'h0000_0001 << i);
            chk("reset pins", gpio_o & 11'h783, 11'h783 & ~(11'h001 << PIN_OF[i]));
        end
        chk("alt oe", gpio_oe, 11'h783);
        apb(1'b1, OFS_EVENT, 32'h0000_0001);
        chk("event pin", gpio_o[7], 1'b0);
        apb(1'b1, OFS_GPIO_ALT, 32'h0000_0100);
        apb(1'b1, OFS_PORT_RST, 32'h0000_0000);
        apb(1'b1, OFS_GPIO_OUT, 32'h0000_02AA);
        apb(1'b1, OFS_GPIO_OE, 32'h0000_07FF);
        chk("mixed out", gpio_o, 11'h3AA);
        apb(1'b0, OFS_GPIO_IN, 32'h0000_0000);
        chk("pin in", rd_q, 32'h0000_03AA);
        apb(1'b1, OFS_GPIO_OE, 32'h0000_0000);
        apb(1'b1, OFS_GPIO_ALT, 32'h0000_003C);
        exp_req <= 4'b0010;
        repeat (4) @(posedge clk_sys);
        chk("expander irq", expander_irq, 4'b0010);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_000F);
        chk("irq", irq, 1'b1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk("status", rd_q, 32'h0000_0002);
        chk("irq cleared", irq, 1'b0);
        exp_req <= 4'b0000;
        boot(1'b1);
        apb(1'b0, OFS_STRAPS, 32'h0000_0000);
        chk("straps", rd_q, 32'h0000_0CA6);
        chk("merged lanes", {port0_x8, port0_lane_count, port1_lane_count}, 9'h180);
        chk("eeprom addr", eeprom_bus_addr[3:0], 4'hC);
        chk("slave addr", slave_bus_addr & 7'h2E, 7'h24);
        slave_rx_addr <= slave_bus_addr;
        @(posedge clk_sys);
        chk("slave hit", slave_addr_hit, 1'b1);
        slave_rx_addr <= slave_bus_addr ^ 7'h20;
        @(posedge clk_sys);
        chk("slave miss", slave_addr_hit, 1'b0);
        burst(SLOW_HALF);
        end_sim;
    end
endmodule
